// ---- pkg/pcstk_pkg.sv ----
// Purpose: Shared constants and carriers for the program counter, return
//          stack and status unit.
// Assumes: One core clock, synchronous active-high reset.
// Notes:   Widths fixed at the documented values.
`default_nettype none
package pcstk_pkg;

  // ---------------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------------
  localparam int         PC_W          = 15;
  localparam int         STK_DEPTH     = 16;
  localparam int         SP_W          = 5;
  localparam logic [4:0] SP_EMPTY      = 5'h1f;
  localparam logic [4:0] SP_TOP        = 5'h0f;
  localparam logic [4:0] SP_BOTTOM     = 5'h00;
  localparam logic [14:0] PC_RESET     = 15'h0000;
  localparam logic [14:0] PC_ONE       = 15'h0001;
  localparam logic [6:0] LATCH_RESET   = 7'h00;
  localparam logic [4:0] STATUS_RESET  = 5'h18;

  // Status bit positions
  localparam int ST_C  = 0;
  localparam int ST_DIG = 1;
  localparam int ST_Z  = 2;
  localparam int ST_PWR = 3;
  localparam int ST_TO = 4;

  // ---------------------------------------------------------------------
  // Program counter source selection
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    PC_HOLD,
    PC_INC,
    PC_WRITE_LOW,
    PC_CALL,
    PC_COMPUTED_CALL,
    PC_BRANCH_WREG,
    PC_BRANCH_LIT,
    PC_VECTOR,
    PC_RETURN
  } pc_op_e;

  // Request from the execution core for one instruction cycle
  typedef struct packed {
    pc_op_e      op;
    logic [10:0] call_target;   // Direct call operand
    logic [8:0]  branch_offset; // Signed literal branch operand
    logic [7:0]  wreg;          // Working register
    logic [7:0]  low_byte_data; // Data written to the pc low byte
    logic [14:0] vector_addr;   // Interrupt vector
  } pc_req_s;

  // Status register write and ALU result
  typedef struct packed {
    logic       write;       // Instruction targets the status register
    logic [4:0] data;        // Value written
    logic       alu_update;  // Instruction updates zero and carries
    logic       is_sub;      // Operation is a subtraction
    logic       zero;        // Result is zero
    logic       carry;       // Raw carry out (borrow for subtraction)
    logic       digit_carry; // Raw digit carry out
    logic       wdt_timeout; // Watchdog timeout event
    logic       sleep_exec;  // Sleep executed
    logic       wd_clear;    // Watchdog clear executed
  } status_req_s;

  // Software access to top-of-stack and pointer
  typedef struct packed {
    logic       ptr_write;
    logic [4:0] ptr_data;
    logic       top_low_write;
    logic       top_high_write;
    logic [7:0] top_data;
  } stack_sw_s;

endpackage : pcstk_pkg
`default_nettype wire

// ---- core/stack_mem.sv ----
// Purpose: Sixteen by fifteen return stack storage.
// Assumes: Single write port, registered read port.
// Notes:   Read data come from a register, one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module stack_mem
  import pcstk_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              wr_en,
  input  wire logic [3:0]        wr_addr,
  input  wire logic [PC_W-1:0]   wr_data,
  input  wire logic [3:0]        rd_addr,
  output var  logic [PC_W-1:0]   rd_data
);

  logic [PC_W-1:0] mem_reg [STK_DEPTH];

  // Write port and registered read with write bypass
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule : stack_mem
`default_nettype wire

// ---- core/pc_stack_status_unit.sv ----
// Purpose: Program counter sequencing, return stack and status flags.
// Assumes: Driven one instruction cycle per clock by the execution core.
// Notes:   Fault reset request is a pulse the system reset logic consumes.
// How it works
// - Zero and carry flags come from result
// - Timeout and power-down flags are read-only
// - Subtraction: carry flags are inverted borrows
// - PC is 15 bits; high from latch
// - Every reset clears the PC
// - Low byte write loads latch high bits
// - Call: operand low bits, latch bits 6:3
// - Computed call: wreg low, latch high
// - Wreg branch: PC+1+unsigned wreg
// - Literal branch: PC+1+signed operand
// - Sixteen by fifteen dedicated return stack
// - Push on calls/vector, pop on returns
// - Push and pop leave latch alone
// - Fault reset off: stack wraps circularly
// - Overflow/underflow flags set regardless of option
// - Fault reset on: reset on overflow/underflow
// - Top entry registers read/write via pointer
// - Push increments then writes; pop reads then decrements
// - Reset pointer 0x1F; top reads per option
`timescale 1ns/1ps
`default_nettype none
module pc_stack_status_unit
  import pcstk_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire pc_req_s           pc_req,
  input  wire logic              latch_write,
  input  wire logic [6:0]        latch_data,
  input  wire status_req_s       status_req,
  input  wire stack_sw_s         stack_sw,
  input  wire logic              stack_fault_reset_enable,
  input  wire logic              flag_clear,
  output logic [PC_W-1:0]        pc_out,
  output logic [7:0]             pc_low_byte,
  output logic [6:0]             pc_high_latch,
  output logic [4:0]             status_out,
  output logic [4:0]             return_stack_pointer,
  output logic [7:0]             top_entry_low,
  output logic [6:0]             top_entry_high,
  output logic                   stack_overflow_flag,
  output logic                   stack_underflow_flag,
  output logic                   stack_fault_reset
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  // Everything the unit remembers, apart from the stack memory, lives in this one record
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [6:0]      latch;
    logic [4:0]      status;
    logic [4:0]      sp;
    logic            ovf;
    logic            unf;
    logic            fault;
    logic [7:0]      top_low;
    logic [6:0]      top_high;
    logic            fresh;   // Top entry must be refreshed from memory
    logic [7:0]      top_low_out;  // Registered top entry seen at the pins
    logic [6:0]      top_high_out;
  } state_s;

  // Present state and the value it takes at the next edge
  state_s state_reg;
  state_s state_next;

  // Stack memory port signals, set by the next-state logic
  logic [PC_W-1:0] mem_rd_data;
  logic            mem_wr_en;
  logic [3:0]      mem_wr_addr;
  logic [PC_W-1:0] mem_wr_data;
  logic [3:0]      mem_rd_addr;

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  // Pointer step with wrap inside the sixteen entries
  // From the empty code the first push lands on entry zero
  function automatic logic [4:0] sp_step(input logic [4:0] sp,
                                         input logic       up);
    logic [3:0] idx;
    idx = sp[3:0];
    if (up) begin
      sp_step = {1'b0, idx + 4'h1};
    end else begin
      sp_step = (sp == SP_BOTTOM) ? SP_EMPTY
                                  : {1'b0, idx - 4'h1};
    end
  endfunction : sp_step

  // Incremented pc plus an offset, full width, page boundary free
  // A 256-word page boundary may be crossed with no special care
  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
                                                 input logic [PC_W-1:0] off);
    rel_target = pc + PC_ONE + off;
  endfunction : rel_target

  // Carry sense: a subtraction reports the inverse of its borrow
  function automatic logic carry_sense(input logic raw,
                                       input logic is_sub);
    carry_sense = is_sub ? ~raw : raw;
  endfunction : carry_sense

  // Overflow: a push while the pointer sits on the last entry
  function automatic logic push_overflows(input logic [4:0] sp);
    push_overflows = (sp == SP_TOP);
  endfunction : push_overflows

  // Underflow: a pop while the stack is empty
  function automatic logic pop_underflows(input logic [4:0] sp);
    pop_underflows = (sp == SP_EMPTY);
  endfunction : pop_underflows

  // -----------------------------------------------------------------------
  // Stack memory
  // -----------------------------------------------------------------------
  // Registered read port: data lag the address by one cycle
  stack_mem u_stack_mem (
    .ref_clk (ref_clk),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_addr (mem_rd_addr),
    .rd_data (mem_rd_data)
  );

  // -----------------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------------
  // Sequencing, stack motion and status flag updates for one cycle
  always_comb begin
    logic            push;
    logic            pop;
    logic [PC_W-1:0] top_entry;
    logic [PC_W-1:0] pc_plus;
    logic [4:0]      st;
    push       = 1'b0;
    pop        = 1'b0;
    top_entry  = '0;
    pc_plus    = '0;
    st         = '0;
    state_next = state_reg;
    state_next.fault = 1'b0;
    mem_wr_en   = 1'b0;
    mem_wr_addr = '0;
    mem_wr_data = '0;
    mem_rd_addr = state_reg.sp[3:0];

    // Current top value, refreshed after pointer motion
    top_entry = state_reg.fresh ? mem_rd_data
                                : {state_reg.top_high, state_reg.top_low};
    if (state_reg.fresh) begin
      state_next.top_low  = mem_rd_data[7:0];
      state_next.top_high = mem_rd_data[14:8];
      state_next.fresh    = 1'b0;
    end
    // Return address stored by every push
    pc_plus = state_reg.pc + PC_ONE;

    // Program counter selection
    case (pc_req.op)
      PC_INC: begin
        state_next.pc = pc_plus;
      end
      PC_WRITE_LOW: begin
        state_next.pc = {state_reg.latch, pc_req.low_byte_data};
      end
      PC_CALL: begin
        state_next.pc = {state_reg.latch[6:3], pc_req.call_target};
        push = 1'b1;
      end
      PC_COMPUTED_CALL: begin
        state_next.pc = {state_reg.latch, pc_req.wreg};
        push = 1'b1;
      end
      PC_BRANCH_WREG: begin
        state_next.pc = rel_target(state_reg.pc,
                                   {7'h00, pc_req.wreg});
      end
      PC_BRANCH_LIT: begin
        state_next.pc = rel_target(state_reg.pc,
          {{(PC_W-9){pc_req.branch_offset[8]}},
           pc_req.branch_offset});
      end
      PC_VECTOR: begin
        state_next.pc = pc_req.vector_addr;
        push = 1'b1;
      end
      PC_RETURN: begin
        state_next.pc = top_entry;
        pop = 1'b1;
      end
      default: begin
        state_next.pc = state_reg.pc;
      end
    endcase

    // Push: pointer moves first, then the return address is stored.
    // On a full stack the write still happens: with the fault option off
    // the oldest entry is overwritten, which gives the circular stack.
    // Software stack access is ignored in a cycle with stack motion.
    if (push) begin
      if (push_overflows(state_reg.sp)) begin
        state_next.ovf = 1'b1;
        state_next.fault = stack_fault_reset_enable;
      end
      state_next.sp = sp_step(state_reg.sp, 1'b1);
      mem_wr_en   = 1'b1;
      mem_wr_addr = state_next.sp[3:0];
      mem_wr_data = pc_plus;
      state_next.top_low  = pc_plus[7:0];
      state_next.top_high = pc_plus[14:8];
      state_next.fresh    = 1'b0;
    end else if (pop) begin
      // The new top is read after the pointer moves, so it lands a cycle
      // later; the fresh bit picks it up from the memory register then
      if (pop_underflows(state_reg.sp)) begin
        state_next.unf = 1'b1;
        state_next.fault = stack_fault_reset_enable;
      end
      state_next.sp = sp_step(state_reg.sp, 1'b0);
      state_next.fresh = 1'b1;
    end else if (stack_sw.ptr_write) begin
      state_next.sp    = stack_sw.ptr_data;
      state_next.fresh = 1'b1;
    end else if (stack_sw.top_low_write || stack_sw.top_high_write) begin
      if (stack_sw.top_low_write) begin
        state_next.top_low = stack_sw.top_data;
      end
      if (stack_sw.top_high_write) begin
        state_next.top_high = stack_sw.top_data[6:0];
      end
      mem_wr_en   = 1'b1;
      mem_wr_addr = state_reg.sp[3:0];
      mem_wr_data = {state_next.top_high, state_next.top_low};
      state_next.fresh = 1'b0;
    end
    mem_rd_addr = state_next.sp[3:0];

    // Sticky stack flags, an event wins over software clear
    if (flag_clear) begin
      state_next.ovf = push && push_overflows(state_reg.sp);
      state_next.unf = pop && pop_underflows(state_reg.sp);
    end

    // Latch is written only by the core, never by stack motion
    if (latch_write) begin
      state_next.latch = latch_data;
    end

    // Status register
    st = state_reg.status;
    if (status_req.write) begin
      st[ST_Z]  = status_req.data[ST_Z];
      st[ST_DIG] = status_req.data[ST_DIG];
      st[ST_C]  = status_req.data[ST_C];
    end
    if (status_req.alu_update) begin
      st[ST_Z]  = status_req.zero;
      st[ST_DIG] = carry_sense(status_req.digit_carry,
                               status_req.is_sub);
      st[ST_C]   = carry_sense(status_req.carry, status_req.is_sub);
    end
    // Timeout and power-down flags move only on their own events; a
    // write aimed at the status register never reaches them
    if (status_req.wd_clear) begin
      st[ST_TO]  = 1'b1;
      st[ST_PWR] = 1'b1;
    end
    if (status_req.sleep_exec) begin
      st[ST_TO]  = 1'b1;
      st[ST_PWR] = 1'b0;
    end
    if (status_req.wdt_timeout) begin
      st[ST_TO] = 1'b0;
    end
    state_next.status = st;

    // A fault reset clears the program counter and sets the stack pointer to empty
    // The request itself is a one-cycle pulse for the system reset logic
    if (state_next.fault) begin
      state_next.pc    = PC_RESET;
      state_next.sp    = SP_EMPTY;
      state_next.fresh = 1'b1;
      mem_rd_addr      = SP_EMPTY[3:0];
    end

    // Visible top entry is registered; it reads zero while the stack is
    // empty with the fault option on, else it shows the selected entry
    if (stack_fault_reset_enable && (state_next.sp == SP_EMPTY)) begin
      state_next.top_low_out  = 8'h00;
      state_next.top_high_out = 7'h00;
    end else begin
      state_next.top_low_out  = state_next.top_low;
      state_next.top_high_out = state_next.top_high;
    end
  end

  // -----------------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------------
  // Reset clears pc and empties the stack; status loads STATUS_RESET, stack flags clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg.pc       <= PC_RESET;
      state_reg.latch    <= LATCH_RESET;
      state_reg.status   <= STATUS_RESET;
      state_reg.sp       <= SP_EMPTY;
      state_reg.ovf      <= 1'b0;
      state_reg.unf      <= 1'b0;
      state_reg.fault    <= 1'b0;
      state_reg.top_low  <= 8'h00;
      state_reg.top_high <= 7'h00;
      state_reg.fresh    <= 1'b1;
      state_reg.top_low_out  <= 8'h00;
      state_reg.top_high_out <= 7'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  // Every output is a plain copy of a state register, so nothing
  // combinational from the inputs reaches a pin
  always_comb begin
    pc_out               = state_reg.pc;
    pc_low_byte          = state_reg.pc[7:0];
    pc_high_latch        = state_reg.latch;
    status_out           = state_reg.status;
    return_stack_pointer = state_reg.sp;
    top_entry_low        = state_reg.top_low_out;
    top_entry_high       = state_reg.top_high_out;
    stack_overflow_flag  = state_reg.ovf;
    stack_underflow_flag = state_reg.unf;
    stack_fault_reset    = state_reg.fault;
  end

endmodule : pc_stack_status_unit
`default_nettype wire

// ---- tb/pcstk_assertions.sv ----
// Purpose: Port checker for the pc, stack and status unit.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound onto the unit; checks relations between its ports.
`timescale 1ns/1ps
`default_nettype none
module pcstk_assertions
  import pcstk_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             sys_rst,
  input wire pc_req_s          pc_req,
  input wire logic             latch_write,
  input wire status_req_s      status_req,
  input wire logic             stack_fault_reset_enable,
  input wire logic [PC_W-1:0]  pc_out,
  input wire logic [6:0]       pc_high_latch,
  input wire logic [4:0]       status_out,
  input wire logic [4:0]       return_stack_pointer,
  input wire logic [7:0]       top_entry_low,
  input wire logic [6:0]       top_entry_high,
  input wire logic             stack_overflow_flag,
  input wire logic             stack_underflow_flag,
  input wire logic             stack_fault_reset
);
  // ----------------------------------------------------------------
  // Helper terms
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic [4:0]  sp    = return_stack_pointer;
  wire logic        push  = pc_req.op inside {PC_CALL, PC_COMPUTED_CALL,
                                              PC_VECTOR};
  wire logic        pop   = pc_req.op == PC_RETURN;
  wire logic        ovf   = push && sp == SP_TOP;
  wire logic        unf   = pop && sp == SP_EMPTY;
  wire logic [3:0]  lat_hi = pc_high_latch[6:3];
  wire logic [7:0]  wreg  = pc_req.wreg;
  wire logic [14:0] off_x = {{6{pc_req.branch_offset[8]}},
                             pc_req.branch_offset};
  wire logic [1:0]  tp    = status_out[4:3];
  wire logic [2:0]  alu_x = {status_req.zero,
                             status_req.digit_carry ^ status_req.is_sub,
                             status_req.carry ^ status_req.is_sub};
  wire logic [4:0]  sp_up = (sp == SP_EMPTY || sp == SP_TOP) ? SP_BOTTOM
                                                             : sp + 5'h01;
  wire logic [4:0]  sp_dn = (sp == SP_BOTTOM) ? SP_EMPTY : sp - 5'h01;
  wire logic        st_ev = status_req.sleep_exec || status_req.wd_clear ||
                            status_req.wdt_timeout;

  property p_rst;
    disable iff (1'b0) sys_rst |=> pc_out == PC_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("pc not cleared");
  property p_wlow;
    pc_req.op == PC_WRITE_LOW && !latch_write |=>
      pc_out == {$past(pc_high_latch), $past(pc_req.low_byte_data)};
  endproperty
  a_wlow: assert property (p_wlow) else $error("bad low write");
  property p_call;
    pc_req.op == PC_CALL && !latch_write && !ovf |=>
      pc_out == {$past(lat_hi), $past(pc_req.call_target)};
  endproperty
  a_call: assert property (p_call) else $error("bad call target");
  property p_brw;
    pc_req.op == PC_BRANCH_WREG |=>
      pc_out == $past(pc_out) + 15'h0001 + 15'($past(wreg));
  endproperty
  a_brw: assert property (p_brw) else $error("bad wreg branch");
  property p_bra;
    pc_req.op == PC_BRANCH_LIT |=>
      pc_out == $past(pc_out) + 15'h0001 + $past(off_x);
  endproperty
  a_bra: assert property (p_bra) else $error("bad lit branch");
  property p_ro;
    status_req.write && !st_ev |=> $stable(tp);
  endproperty
  a_ro: assert property (p_ro) else $error("read-only flag written");
  property p_alu;
    status_req.alu_update |=> status_out[2:0] == $past(alu_x);
  endproperty
  a_alu: assert property (p_alu) else $error("bad alu flags");
  property p_push;
    push && !(ovf && stack_fault_reset_enable) |=> sp == $past(sp_up);
  endproperty
  a_push: assert property (p_push) else $error("bad push ptr");
  property p_pop;
    pop && sp != SP_EMPTY |=> sp == $past(sp_dn);
  endproperty
  a_pop: assert property (p_pop) else $error("bad pop ptr");
  property p_flags;
    (ovf |=> stack_overflow_flag) and (unf |=> stack_underflow_flag);
  endproperty
  a_flags: assert property (p_flags) else $error("flag not set");
  property p_flt;
    (ovf || unf) && stack_fault_reset_enable |=>
      stack_fault_reset && pc_out == PC_RESET;
  endproperty
  a_flt: assert property (p_flt) else $error("no fault reset");
  property p_nflt;
    stack_fault_reset |-> $past(stack_fault_reset_enable);
  endproperty
  a_nflt: assert property (p_nflt) else $error("fault when off");
  property p_top0;
    sp == SP_EMPTY && stack_fault_reset_enable |->
      {top_entry_high, top_entry_low} == 15'h0000;
  endproperty
  a_top0: assert property (p_top0) else $error("top not zero");
  property p_lat;
    (push || pop) && !latch_write |=> $stable(pc_high_latch);
  endproperty
  a_lat: assert property (p_lat) else $error("latch moved");

  // Main scenarios reached
  c_ovf: cover property (ovf);
  c_unf: cover property (unf);
  c_flt: cover property (stack_fault_reset);
endmodule : pcstk_assertions

bind pc_stack_status_unit pcstk_assertions chk_i (.*);
`default_nettype wire

// ---- tb/exec_core_model.sv ----
// Purpose: Execution core stand-in issuing one request per call.
// Assumes: Requests change on the falling edge only.
// Notes:   Each request lasts one cycle, then the core goes quiet.
`timescale 1ns/1ps
`default_nettype none
module exec_core_model
  import pcstk_pkg::*;
(
  input  wire logic        ref_clk,
  output var  pc_req_s     pc_req,
  output var  logic        latch_write,
  output var  logic [6:0]  latch_data,
  output var  status_req_s status_req,
  output var  stack_sw_s   stack_sw,
  output var  logic        flag_clear
);
  // ----------------------------------------------------------------
  // Request tasks
  // ----------------------------------------------------------------
  task automatic quiet();
    pc_req      = '0;
    latch_write = 1'b0;
    status_req  = '0;
    stack_sw    = '0;
    flag_clear  = 1'b0;
  endtask : quiet
  initial begin
    latch_data = 7'h00;
    quiet();
  end
  task automatic idle();
    @(negedge ref_clk);
    quiet();
  endtask : idle
  task automatic run(input pc_req_s r);
    @(negedge ref_clk);
    pc_req = r;
    idle();
  endtask : run
  task automatic lat(input logic [6:0] d);
    @(negedge ref_clk);
    latch_write = 1'b1;
    latch_data  = d;
    idle();
  endtask : lat
  task automatic stat(input status_req_s s);
    @(negedge ref_clk);
    status_req = s;
    idle();
  endtask : stat
  task automatic swr(input stack_sw_s t);
    @(negedge ref_clk);
    stack_sw = t;
    idle();
  endtask : swr
  task automatic clr();
    @(negedge ref_clk);
    flag_clear = 1'b1;
    idle();
  endtask : clr
endmodule : exec_core_model
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the pc, stack and status unit.
// Assumes: Results are settled at the falling edge after a request.
// Notes:   The core stand-in drives every request input.
`timescale 1ns/1ps
`default_nettype none
module tb
  import pcstk_pkg::*;
;
  logic             ref_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             stack_fault_reset_enable = 1'b1;
  pc_req_s          pc_req;
  status_req_s      status_req;
  stack_sw_s        stack_sw;
  logic             latch_write, flag_clear;
  logic [6:0]       latch_data, pc_high_latch, top_entry_high;
  logic [14:0]      pc_out;
  logic [7:0]       pc_low_byte, top_entry_low;
  logic [4:0]       status_out, return_stack_pointer;
  logic             stack_overflow_flag, stack_underflow_flag;
  logic             stack_fault_reset;
  int               num_errors = 0;
  int               n_tests = 0;
  status_req_s      s;
  stack_sw_s        t;
  wire logic [14:0] top = {top_entry_high, top_entry_low};
  wire logic [14:0] sp  = 15'(return_stack_pointer);
  wire logic [14:0] st  = 15'(status_out);
  wire logic [14:0] flg = 15'({stack_fault_reset, stack_underflow_flag,
                               stack_overflow_flag});

  // ----------------------------------------------------------------
  // Clock, instances and helpers
  // ----------------------------------------------------------------
  always #25 ref_clk = ~ref_clk;
  pc_stack_status_unit dut (.*);
  exec_core_model core (.*);

  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input pc_op_e op, input logic [14:0] v);
    core.run('{op, v[10:0], v[8:0], v[7:0], v[7:0], v});
  endtask : go
  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Hang guard
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    core.idle();
    chk(pc_out, PC_RESET);
    chk(sp, 15'h001f);
    chk(st, 15'(STATUS_RESET));
    chk(top, 15'h0000);
    stack_fault_reset_enable = 1'b0;
    done("reset");
    core.lat(7'h55);
    go(PC_WRITE_LOW, 15'h00a7);
    chk(pc_out, 15'h55a7);
    chk(15'(pc_low_byte), 15'h00a7);
    go(PC_CALL, 15'h0123);
    chk(pc_out, 15'h5123);
    chk(sp, 15'h0000);
    chk(15'(pc_high_latch), 15'h0055);
    core.idle();
    chk(top, 15'h55a8);
    go(PC_COMPUTED_CALL, 15'h003c);
    chk(pc_out, 15'h553c);
    go(PC_RETURN, 15'h0000);
    chk(pc_out, 15'h5124);
    core.idle();
    go(PC_RETURN, 15'h0000);
    chk(pc_out, 15'h55a8);
    chk(sp, 15'h001f);
    done("calls");
    go(PC_BRANCH_WREG, 15'h00ff);
    chk(pc_out, 15'h56a8);
    go(PC_BRANCH_LIT, 15'h01f0);
    chk(pc_out, 15'h5699);
    go(PC_BRANCH_LIT, 15'h00ff);
    chk(pc_out, 15'h5799);
    go(PC_INC, 15'h0000);
    chk(pc_out, 15'h579a);
    done("branches");
    s = '0;
    s.write = 1'b1;
    s.data = 5'h01;
    s.alu_update = 1'b1;
    s.is_sub = 1'b1;
    s.zero = 1'b1;
    s.carry = 1'b1;
    core.stat(s);
    chk(st, 15'h001e);
    s.is_sub = 1'b0;
    s.zero = 1'b0;
    core.stat(s);
    chk(st, 15'h0019);
    s = '0;
    s.write = 1'b1;
    core.stat(s);
    chk(st, 15'h0018);
    s.write = 1'b0;
    s.sleep_exec = 1'b1;
    core.stat(s);
    chk(st, 15'h0010);
    s = '0;
    s.wdt_timeout = 1'b1;
    core.stat(s);
    chk(st, 15'h0000);
    s = '0;
    s.write = 1'b1;
    s.data = 5'h1f;
    core.stat(s);
    chk(st, 15'h0007);
    s = '0;
    s.wd_clear = 1'b1;
    core.stat(s);
    chk(st, 15'h001f);
    done("status");
    for (int i = 0; i < 17; i++)
      go(PC_VECTOR, 15'(15'h0100 + i));
    chk(sp, 15'h0000);
    chk(flg, 15'h0001);
    core.idle();
    chk(top, 15'h0110);
    t = '0;
    t.ptr_write = 1'b1;
    t.ptr_data = 5'h05;
    core.swr(t);
    core.idle();
    chk(top, 15'h0105);
    t = '0;
    t.top_low_write = 1'b1;
    t.top_data = 8'haa;
    core.swr(t);
    t = '0;
    t.top_high_write = 1'b1;
    t.top_data = 8'h12;
    core.swr(t);
    core.idle();
    chk(top, 15'h12aa);
    go(PC_RETURN, 15'h0000);
    chk(pc_out, 15'h12aa);
    chk(sp, 15'h0004);
    core.clr();
    chk(flg, 15'h0000);
    t = '0;
    t.ptr_write = 1'b1;
    t.ptr_data = 5'h1f;
    core.swr(t);
    go(PC_RETURN, 15'h0000);
    chk(flg, 15'h0002);
    done("circular");
    stack_fault_reset_enable = 1'b1;
    core.clr();
    t.ptr_data = 5'h0f;
    core.swr(t);
    go(PC_CALL, 15'h0001);
    chk(flg, 15'h0005);
    chk(pc_out, PC_RESET);
    chk(sp, 15'h001f);
    chk(top, 15'h0000);
    core.clr();
    go(PC_RETURN, 15'h0000);
    chk(flg, 15'h0006);
    done("fault");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
